// File: logic/ipa_arbiter.sv
// Interrupt priority arbiter with APB registers, transfer channels and stack save
//
// Local design decisions: register access over APB and the register offsets.
`include "ipa_cfg.svh"
module ipa_arbiter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`IPA_NSRC-1:0] req_in,
  output logic int_ack,
  output logic [3:0] vec_index,
  output logic [3:0] vec_level,
  output logic xfer_valid,
  output logic [2:0] xfer_chan,
  output logic stack_valid,
  output logic [15:0] stack_data,
  output logic irq
);

  ipa_pkg::ipa_state_t s_q;
  ipa_pkg::ipa_state_t s_d;

  logic [`IPA_NSRC-1:0] elig;
  logic found;
  logic [3:0] widx;
  logic [3:0] cpu_prio;
  logic [3:0] wlvl;
  logic [2:0] wchan;
  logic [7:0] wcnt;
  logic xfer_lvl;
  logic xfer_ok;
  logic grant;
  logic wr;
  logic rd;
  logic [3:0] aidx;
  logic [`IPA_NEVT-1:0] evt;

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  assign cpu_prio = s_q.prog[`IPA_PROG_PRIO];

  // Flags are kept whatever the priority; only the grant is held back
  for (genvar i = 0; i < `IPA_NSRC; i++) begin : g_elig
    assign elig[i] = s_q.flag[i] && s_q.src[i].en
                     && s_q.src[i].lvl != `IPA_LVL_NONE;
  end

  ipa_pick u_pick (
    .elig(elig),
    .src(s_q.src),
    .found(found),
    .idx(widx)
  );

  assign wlvl = s_q.src[widx].lvl;
  assign wchan = {wlvl[0], s_q.src[widx].grp};
  assign wcnt = s_q.cnt[wchan];
  assign xfer_lvl = wlvl == `IPA_LVL_XFER_HI || wlvl == `IPA_LVL_XFER_LO;
  // Channel gating by CPU level
  assign xfer_ok = xfer_lvl && wcnt != `IPA_CNT_ZERO
                   && cpu_prio != `IPA_LVL_XFER_HI
                   && (cpu_prio != `IPA_LVL_XFER_LO || wchan >= `IPA_CHAN_HALF);
  // A fresh round every cycle; no grant while the stack save runs
  assign grant = found && s_q.prog[`IPA_PROG_GIE]
                 && wlvl > cpu_prio && s_q.push == ipa_pkg::IPA_IDLE;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign aidx = paddr[5:2];
  assign pready = 1'b1;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    evt = '0;
    s_d.int_ack = 1'b0;
    s_d.xfer_valid = 1'b0;
    s_d.stack_valid = 1'b0;

    // Software writes first, hardware effects override them
    if (wr) begin
      if (paddr == `IPA_OFF_PROG) begin
        s_d.prog = pwdata[15:0];
      end else if (paddr == `IPA_OFF_SYSCFG) begin
        s_d.segdis = pwdata[0];
      end else if (paddr == `IPA_OFF_CSEG) begin
        s_d.cseg = pwdata[15:0];
      end else if (paddr == `IPA_OFF_IPTR) begin
        s_d.iptr = pwdata[15:0];
      end else if (paddr == `IPA_OFF_STS) begin
        s_d.sts = s_q.sts & ~pwdata[`IPA_NEVT-1:0];
      end else if (paddr == `IPA_OFF_MSK) begin
        s_d.msk = pwdata[`IPA_NEVT-1:0];
      end else if ((paddr & `IPA_SRC_MASK) == `IPA_OFF_SRC) begin
        s_d.src[aidx].lvl = pwdata[`IPA_SRC_LVL];
        s_d.src[aidx].grp = pwdata[`IPA_SRC_GRP];
        s_d.src[aidx].en = pwdata[`IPA_SRC_EN];
        s_d.flag[aidx] = pwdata[`IPA_SRC_FLAG];
      end else if ((paddr & `IPA_CNT_MASK) == `IPA_OFF_CNT) begin
        s_d.cnt[aidx[2:0]] = pwdata[7:0];
      end
    end

    // Grant: transfer service or CPU interrupt
    if (grant) begin
      s_d.vec_index = widx;
      s_d.vec_level = wlvl;
      s_d.vec_group = s_q.src[widx].grp;
      if (xfer_ok) begin
        s_d.xfer_valid = 1'b1;
        s_d.xfer_chan = wchan;
        evt[`IPA_EVT_XFER] = 1'b1;
        // Counter 1 leaves the flag set so the next round interrupts
        if (wcnt != `IPA_CNT_ONE) begin
          s_d.flag[widx] = 1'b0;
        end
        if (wcnt != `IPA_CNT_CONT) begin
          s_d.cnt[wchan] = wcnt - `IPA_CNT_ONE;
        end
        if (wcnt == `IPA_CNT_ONE) begin
          evt[`IPA_EVT_ZERO] = 1'b1;
        end
      end else begin
        s_d.int_ack = 1'b1;
        s_d.prog_sv = s_q.prog;
        s_d.prog[`IPA_PROG_PRIO] = wlvl;
        s_d.flag[widx] = 1'b0;
        s_d.push = ipa_pkg::IPA_PUSH_PROG;
        evt[`IPA_EVT_ACK] = 1'b1;
      end
    end

    // New requests win over any clear in the same cycle
    s_d.flag = s_d.flag | req_in;

    // Stack save sequence
    case (s_q.push)
      ipa_pkg::IPA_IDLE: begin
      end
      ipa_pkg::IPA_PUSH_PROG: begin
        s_d.stack_valid = 1'b1;
        s_d.stack_data = s_q.prog_sv;
        s_d.push = s_q.segdis ? ipa_pkg::IPA_PUSH_IPTR : ipa_pkg::IPA_PUSH_CSEG;
      end
      ipa_pkg::IPA_PUSH_CSEG: begin
        s_d.stack_valid = 1'b1;
        s_d.stack_data = s_q.cseg;
        s_d.cseg = `IPA_RST_WORD;
        s_d.push = ipa_pkg::IPA_PUSH_IPTR;
      end
      ipa_pkg::IPA_PUSH_IPTR: begin
        s_d.stack_valid = 1'b1;
        s_d.stack_data = s_q.iptr;
        s_d.push = ipa_pkg::IPA_IDLE;
      end
      default: begin
        s_d.push = ipa_pkg::IPA_IDLE;
      end
    endcase

    s_d.sts = s_d.sts | evt;

    // Read data latched in the setup phase, shown in the access phase
    if (psel && !penable) begin
      s_d.pslverr = 1'b0;
      s_d.prdata = '0;
      if (paddr == `IPA_OFF_PROG) begin
        s_d.prdata[15:0] = s_q.prog;
      end else if (paddr == `IPA_OFF_SYSCFG) begin
        s_d.prdata[0] = s_q.segdis;
      end else if (paddr == `IPA_OFF_CSEG) begin
        s_d.prdata[15:0] = s_q.cseg;
      end else if (paddr == `IPA_OFF_IPTR) begin
        s_d.prdata[15:0] = s_q.iptr;
      end else if (paddr == `IPA_OFF_STS) begin
        s_d.prdata[`IPA_NEVT-1:0] = s_q.sts;
      end else if (paddr == `IPA_OFF_MSK) begin
        s_d.prdata[`IPA_NEVT-1:0] = s_q.msk;
      end else if (paddr == `IPA_OFF_WIN) begin
        s_d.prdata[10:0] = {found, s_q.vec_group, s_q.vec_level, s_q.vec_index};
      end else if ((paddr & `IPA_SRC_MASK) == `IPA_OFF_SRC) begin
        s_d.prdata[7:0] = {s_q.flag[aidx], s_q.src[aidx]};
      end else if ((paddr & `IPA_CNT_MASK) == `IPA_OFF_CNT) begin
        s_d.prdata[7:0] = s_q.cnt[aidx[2:0]];
      end else begin
        // Unmapped offsets read zero; the error shows only in the access phase
        s_d.pslverr = 1'b1;
      end
      if (!rd) begin
        s_d.prdata = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.prog <= `IPA_RST_PROG;
      s_q.segdis <= `IPA_RST_SEGDIS;
      s_q.push <= ipa_pkg::IPA_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr && psel && penable;
  assign int_ack = s_q.int_ack;
  assign vec_index = s_q.vec_index;
  assign vec_level = s_q.vec_level;
  assign xfer_valid = s_q.xfer_valid;
  assign xfer_chan = s_q.xfer_chan;
  assign stack_valid = s_q.stack_valid;
  assign stack_data = s_q.stack_data;
  assign irq = |(s_q.sts & s_q.msk);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_gie_off;
    @(posedge pclk) disable iff (!presetn)
    !s_q.prog[`IPA_PROG_GIE] |-> ##1 !(int_ack || xfer_valid);
  endproperty
  a_gie_off: assert property (p_gie_off) else $error("grant with global enable off");

  property p_enabled;
    @(posedge pclk) disable iff (!presetn)
    int_ack || xfer_valid |-> $past(s_q.src[widx].en) && $past(s_q.flag[widx])
      && vec_level != `IPA_LVL_NONE;
  endproperty
  a_enabled: assert property (p_enabled) else $error("grant to disabled or level 0 source");

  property p_above;
    @(posedge pclk) disable iff (!presetn)
    int_ack |-> $past(cpu_prio) < vec_level && cpu_prio == vec_level;
  endproperty
  a_above: assert property (p_above) else $error("ack not above CPU priority");

  property p_flag_clr;
    @(posedge pclk) disable iff (!presetn)
    int_ack && !$past(req_in[widx]) |-> !s_q.flag[vec_index];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared on ack");

  property p_pending;
    @(posedge pclk) disable iff (!presetn)
    s_q.flag[0] && !wr && !(grant && widx == 4'h0) |=> s_q.flag[0];
  endproperty
  a_pending: assert property (p_pending) else $error("pending flag lost");

  property p_seg;
    @(posedge pclk) disable iff (!presetn)
    int_ack && !s_q.segdis |-> ##1 stack_valid && stack_data == $past(s_q.prog_sv)
      ##1 stack_valid ##1 stack_valid && s_q.cseg == `IPA_RST_WORD ##1 !stack_valid;
  endproperty
  a_seg: assert property (p_seg) else $error("segmented save order wrong");

  property p_noseg;
    @(posedge pclk) disable iff (!presetn)
    int_ack && s_q.segdis |-> ##1 stack_valid [*2] ##1 !stack_valid;
  endproperty
  a_noseg: assert property (p_noseg) else $error("flat save length wrong");

  property p_cnt;
    @(posedge pclk) disable iff (!presetn)
    xfer_valid |-> $past(wcnt) != `IPA_CNT_ZERO && $past(cpu_prio) != `IPA_LVL_XFER_HI
      && ($past(cpu_prio) != `IPA_LVL_XFER_LO || xfer_chan >= `IPA_CHAN_HALF);
  endproperty
  a_cnt: assert property (p_cnt) else $error("transfer with zero count or blocked channel");

  property p_best;
    @(posedge pclk) disable iff (!presetn)
    found |-> !(elig[0] && {s_q.src[0].lvl, s_q.src[0].grp} > {wlvl, s_q.src[widx].grp});
  endproperty
  a_best: assert property (p_best) else $error("winner not highest");

  property p_fresh;
    @(posedge pclk) disable iff (!presetn)
    found && s_q.prog[`IPA_PROG_GIE] && wlvl > cpu_prio && s_q.push == ipa_pkg::IPA_IDLE
      |=> int_ack || xfer_valid;
  endproperty
  a_fresh: assert property (p_fresh) else $error("eligible winner above CPU priority not granted");

  property p_cnt_one;
    @(posedge pclk) disable iff (!presetn)
    xfer_valid && $past(wcnt) == `IPA_CNT_ONE && !$past(wr) |-> s_q.flag[vec_index]
      && s_q.cnt[xfer_chan] == `IPA_CNT_ZERO;
  endproperty
  a_cnt_one: assert property (p_cnt_one) else $error("count of one did not keep the flag");

  property p_top_level;
    @(posedge pclk) disable iff (!presetn)
    cpu_prio == `IPA_LVL_XFER_HI |=> !xfer_valid;
  endproperty
  a_top_level: assert property (p_top_level) else $error("transfer while CPU at top level");

endmodule : ipa_arbiter

// File: logic/ipa_cfg.svh
// Constants of the interrupt priority arbiter: offsets, fields, reset values
//
// Overview of operation
// - Competition among enabled pending requests runs again every instruction cycle.
// - Each source has its own enable; disabled sources never compete.
// - With global_irq_enable clear nothing is acknowledged; once set, enabled sources compete.
// - A source at level 0 never interrupts the CPU.
// - Requests at or below the CPU priority do not interrupt.
// - Group priority 0 to 3 ranks up to four sources inside one level.
// - Winner is highest level, then highest group within that level.
// - Winner acknowledged only above CPU priority; control passes to its vector.
// - Sixteen levels, fifteen effective, so fifteen routines may nest.
// - Levels 15 and 14 do transfers, or interrupt when channel counter is zero.
// - CPU priority shows the serviced level; software rewrites are used at once.
// - Requests at or below CPU priority stay pending with flags held.
// - On selection the task state is saved; content depends on segmentation_disable_bit.
// - On acknowledge the level goes into CPU priority and the flag clears.
// - At CPU level 14 only channels 4-7 transfer; at 15 none.
// - Segmented save order is status, code segment, instruction pointer; segment forced zero.
`ifndef IPA_CFG_SVH
`define IPA_CFG_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define IPA_NSRC 16
`define IPA_NCHAN 8
`define IPA_NEVT 3

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define IPA_OFF_PROG 8'h00
`define IPA_OFF_SYSCFG 8'h04
`define IPA_OFF_CSEG 8'h08
`define IPA_OFF_IPTR 8'h0C
`define IPA_OFF_STS 8'h10
`define IPA_OFF_MSK 8'h14
`define IPA_OFF_WIN 8'h18
`define IPA_OFF_SRC 8'h40
`define IPA_OFF_CNT 8'h80
`define IPA_SRC_MASK 8'hC0
`define IPA_CNT_MASK 8'hE0

// ----------------------------------------------------------------
// Field positions and special values
// ----------------------------------------------------------------
`define IPA_PROG_GIE 11
`define IPA_PROG_PRIO 15:12
`define IPA_SRC_LVL 3:0
`define IPA_SRC_GRP 5:4
`define IPA_SRC_EN 6
`define IPA_SRC_FLAG 7
`define IPA_EVT_ACK 0
`define IPA_EVT_XFER 1
`define IPA_EVT_ZERO 2
`define IPA_LVL_NONE 4'h0
`define IPA_LVL_XFER_HI 4'hF
`define IPA_LVL_XFER_LO 4'hE
`define IPA_CHAN_HALF 3'h4
`define IPA_CNT_ZERO 8'h00
`define IPA_CNT_ONE 8'h01
`define IPA_CNT_CONT 8'hFF

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IPA_RST_PROG 16'h0000
`define IPA_RST_SEGDIS 1'b1
`define IPA_RST_WORD 16'h0000

`endif

// File: logic/ipa_pick.sv
// Winner search: highest level, then highest group, among eligible sources
`include "ipa_cfg.svh"
module ipa_pick (
  input wire logic [`IPA_NSRC-1:0] elig,
  input wire ipa_pkg::ipa_src_t [`IPA_NSRC-1:0] src,
  output logic found,
  output logic [3:0] idx
);

  logic [5:0] best;

  // Ties keep the lowest index; unique keys make this moot
  always_comb begin
    found = 1'b0;
    idx = 4'h0;
    best = 6'h00;
    for (int i = 0; i < `IPA_NSRC; i++) begin
      if (elig[i] && (!found || {src[i].lvl, src[i].grp} > best)) begin
        found = 1'b1;
        idx = 4'(i);
        best = {src[i].lvl, src[i].grp};
      end
    end
  end

endmodule : ipa_pick

// File: logic/ipa_pkg.sv
// Types shared by the interrupt priority arbiter files
`include "ipa_cfg.svh"
package ipa_pkg;

  typedef struct packed {
    logic en;
    logic [1:0] grp;
    logic [3:0] lvl;
  } ipa_src_t;

  typedef enum logic [1:0] {
    IPA_IDLE,
    IPA_PUSH_PROG,
    IPA_PUSH_CSEG,
    IPA_PUSH_IPTR
  } ipa_push_t;

  typedef struct packed {
    ipa_src_t [`IPA_NSRC-1:0] src;
    logic [`IPA_NSRC-1:0] flag;
    logic [`IPA_NCHAN-1:0][7:0] cnt;
    logic [15:0] prog;
    logic segdis;
    logic [15:0] cseg;
    logic [15:0] iptr;
    logic [15:0] prog_sv;
    logic [`IPA_NEVT-1:0] sts;
    logic [`IPA_NEVT-1:0] msk;
    logic int_ack;
    logic [3:0] vec_index;
    logic [3:0] vec_level;
    logic [1:0] vec_group;
    logic xfer_valid;
    logic [2:0] xfer_chan;
    ipa_push_t push;
    logic stack_valid;
    logic [15:0] stack_data;
    logic [31:0] prdata;
    logic pslverr;
  } ipa_state_t;

endpackage : ipa_pkg

// File: test/ipa_cpu_model.sv
// CPU-side model: counts grants and collects stacked words
module ipa_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic int_ack,
  input wire logic [3:0] vec_index,
  input wire logic [3:0] vec_level,
  input wire logic xfer_valid,
  input wire logic [2:0] xfer_chan,
  input wire logic stack_valid,
  input wire logic [15:0] stack_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int acks;
  int xfers;
  logic [3:0] idx;
  logic [3:0] lvl;
  logic [2:0] chan;
  logic [15:0] stk[$];
  // ------
  // Capture
  // ------
  // Pure observer: the core never stalls a grant, so nothing is driven back
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acks <= 0;
      xfers <= 0;
    end else begin
      if (int_ack || xfer_valid) begin
        idx <= vec_index;
        lvl <= vec_level;
      end
      if (int_ack) begin
        acks <= acks + 1;
      end
      if (xfer_valid) begin
        xfers <= xfers + 1;
        chan <= xfer_chan;
      end
      if (stack_valid) begin
        stk.push_back(stack_data);
      end
    end
  end
endmodule : ipa_cpu_model

// File: test/tb_interrupt_priority_arbiter.sv
// Self-checking bench for the interrupt priority arbiter
`include "ipa_cfg.svh"
module tb_interrupt_priority_arbiter;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] req_in = 16'h0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic int_ack;
  logic [3:0] vec_index;
  logic [3:0] vec_level;
  logic xfer_valid;
  logic [2:0] xfer_chan;
  logic stack_valid;
  logic [15:0] stack_data;
  logic irq;
  logic last_err;
  logic [31:0] rdat;
  int fail_count = 0;
  int tests_run = 0;

  always #5 pclk = ~pclk;

  ipa_arbiter dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_in(req_in), .int_ack(int_ack), .vec_index(vec_index),
    .vec_level(vec_level), .xfer_valid(xfer_valid), .xfer_chan(xfer_chan),
    .stack_valid(stack_valid), .stack_data(stack_data), .irq(irq));

  ipa_cpu_model cpu_u (.pclk(pclk), .presetn(presetn), .int_ack(int_ack),
    .vec_index(vec_index), .vec_level(vec_level), .xfer_valid(xfer_valid),
    .xfer_chan(xfer_chan), .stack_valid(stack_valid), .stack_data(stack_data));

  // ------
  // Tasks
  // ------
  task print_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  task hang;
    fail_count++;
    $display("[ERR] %0t wait ran out", $time);
    print_verdict();
  endtask : hang

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request held until pready is seen high; no wait count is assumed
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) hang();
    rdat = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd

  task pulse(input logic [15:0] m);
    @(posedge pclk);
    req_in <= m;
    @(posedge pclk);
    req_in <= 16'h0000;
  endtask : pulse

  task idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  task wait_ev(input bit x, input int n);
    int k;
    k = 0;
    while ((x ? cpu_u.xfers : cpu_u.acks) != n && k < 50) begin
      @(negedge pclk);
      k++;
    end
    if ((x ? cpu_u.xfers : cpu_u.acks) != n) hang();
  endtask : wait_ev

  task chk_irq(input logic e);
    @(negedge pclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : chk_irq

  // ------
  // Sequence
  // ------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(`IPA_OFF_PROG, 32'h0);
    rd(`IPA_OFF_SYSCFG, 32'h1);
    rd(8'h1C, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    wr(`IPA_OFF_MSK, 32'h1);
    wr(`IPA_OFF_IPTR, 32'h1234);
    wr(`IPA_OFF_SRC + 8'h0C, 32'h45);
    pulse(16'h0008);
    idle(8);
    chk(cpu_u.acks, 32'h0);
    rd(`IPA_OFF_SRC + 8'h0C, 32'hC5);
    wr(`IPA_OFF_PROG, 32'h800);
    wait_ev(1'b0, 1);
    chk({28'h0, cpu_u.idx}, 32'h3);
    chk({28'h0, cpu_u.lvl}, 32'h5);
    idle(6);
    chk(cpu_u.stk.size(), 32'h2);
    chk({16'h0, cpu_u.stk[0]}, 32'h0800);
    chk({16'h0, cpu_u.stk[1]}, 32'h1234);
    rd(`IPA_OFF_PROG, 32'h5800);
    rd(`IPA_OFF_SRC + 8'h0C, 32'h45);
    chk_irq(1'b1);
    wr(`IPA_OFF_MSK, 32'h0);
    chk_irq(1'b0);
    rd(`IPA_OFF_STS, 32'h1);
    wr(`IPA_OFF_STS, 32'h1);
    rd(`IPA_OFF_STS, 32'h0);
    wr(`IPA_OFF_MSK, 32'h1);
    // Equal level to CPU priority waits for software to lower it
    wr(`IPA_OFF_SRC + 8'h10, 32'h55);
    pulse(16'h0010);
    idle(8);
    chk(cpu_u.acks, 32'h1);
    rd(`IPA_OFF_SRC + 8'h10, 32'hD5);
    wr(`IPA_OFF_PROG, 32'h4800);
    wait_ev(1'b0, 2);
    chk({28'h0, cpu_u.idx}, 32'h4);
    wr(`IPA_OFF_PROG, 32'h800);
    wr(`IPA_OFF_SRC + 8'h14, 32'h40);
    wr(`IPA_OFF_SRC + 8'h1C, 32'h09);
    pulse(16'h00A0);
    idle(8);
    chk(cpu_u.acks, 32'h2);
    wr(`IPA_OFF_SRC + 8'h00, 32'h47);
    wr(`IPA_OFF_SRC + 8'h04, 32'h67);
    wr(`IPA_OFF_SRC + 8'h08, 32'h76);
    pulse(16'h0007);
    wait_ev(1'b0, 3);
    chk({28'h0, cpu_u.idx}, 32'h1);
    chk({28'h0, cpu_u.lvl}, 32'h7);
    idle(6);
    wr(`IPA_OFF_PROG, 32'h800);
    wait_ev(1'b0, 4);
    chk({28'h0, cpu_u.idx}, 32'h0);
    idle(6);
    wr(`IPA_OFF_SYSCFG, 32'h0);
    wr(`IPA_OFF_CSEG, 32'hAB);
    cpu_u.stk.delete();
    wr(`IPA_OFF_PROG, 32'h800);
    wait_ev(1'b0, 5);
    idle(6);
    chk({28'h0, cpu_u.idx}, 32'h2);
    chk(cpu_u.stk.size(), 32'h3);
    chk({16'h0, cpu_u.stk[0]}, 32'h0800);
    chk({16'h0, cpu_u.stk[1]}, 32'hAB);
    chk({16'h0, cpu_u.stk[2]}, 32'h1234);
    rd(`IPA_OFF_CSEG, 32'h0);
    // Count of one: a transfer, then the same source interrupts
    wr(`IPA_OFF_SRC + 8'h18, 32'h5E);
    wr(`IPA_OFF_CNT + 8'h04, 32'h1);
    wr(`IPA_OFF_PROG, 32'h800);
    pulse(16'h0040);
    wait_ev(1'b0, 6);
    chk(cpu_u.xfers, 32'h1);
    chk({29'h0, cpu_u.chan}, 32'h1);
    chk({28'h0, cpu_u.lvl}, 32'hE);
    rd(`IPA_OFF_CNT + 8'h04, 32'h0);
    idle(6);
    wr(`IPA_OFF_SRC + 8'h20, 32'h4F);
    wr(`IPA_OFF_CNT + 8'h10, 32'h5);
    pulse(16'h0100);
    wait_ev(1'b1, 2);
    chk({29'h0, cpu_u.chan}, 32'h4);
    rd(`IPA_OFF_CNT + 8'h10, 32'h4);
    rd(`IPA_OFF_STS, 32'h7);
    // At the top CPU level a transfer request stays pending
    wr(`IPA_OFF_PROG, 32'hF800);
    pulse(16'h0100);
    idle(8);
    chk(cpu_u.xfers, 32'h2);
    rd(`IPA_OFF_SRC + 8'h20, 32'hCF);
    rd(`IPA_OFF_WIN, 32'h4F8);
    print_verdict();
  end
endmodule : tb_interrupt_priority_arbiter
